// file: include/uart_regs_pkg.sv
// Constants and carrier types for the banked UART register decoder
package uart_regs_pkg;

    localparam int          DATA_W = 8;
    localparam int          ADDR_W = 3;

    // Host-visible locations
    localparam logic [2:0]  ADDR_0 = 3'h0;
    localparam logic [2:0]  ADDR_1 = 3'h1;
    localparam logic [2:0]  ADDR_2 = 3'h2;
    localparam logic [2:0]  ADDR_3 = 3'h3;
    localparam logic [2:0]  ADDR_4 = 3'h4;
    localparam logic [2:0]  ADDR_5 = 3'h5;
    localparam logic [2:0]  ADDR_6 = 3'h6;
    localparam logic [2:0]  ADDR_7 = 3'h7;

    // Line-setup value that opens the enhanced bank
    localparam logic [7:0]  ENH_BANK_KEY   = 8'hbf;
    localparam logic [7:0]  DIVISOR_ZERO   = 8'h00;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;

    // Field positions
    localparam int          LS_DIV_BIT     = 7;
    localparam int          EF_ENH_BIT     = 4;
    localparam int          FS_SEL_BIT     = 6;
    localparam int          FIFO_RXRST_BIT = 1;
    localparam int          FIFO_TXRST_BIT = 2;

    // Enhanced-only bits of the interrupt enable and status bytes
    localparam logic [7:0]  INT_EN_ENH_MASK = 8'hf0;
    localparam logic [7:0]  INT_ST_ENH_MASK = 8'h30;
    // Reset bits of the FIFO setup byte never stay set
    localparam logic [7:0]  FIFO_KEEP_MASK = 8'hf9;

    // Reset value of every stored byte
    localparam logic [7:0]  RST_REG_VALUE  = 8'h00;

    // Index of each stored byte in the register bank
    localparam int          REG_DIV_LOW  = 0;
    localparam int          REG_DIV_HIGH = 1;
    localparam int          REG_DIV_FRAC = 2;
    localparam int          REG_INT_EN   = 3;
    localparam int          REG_FIFO     = 4;
    localparam int          REG_LINE     = 5;
    localparam int          REG_MODEM    = 6;
    localparam int          REG_MSW      = 7;
    localparam int          REG_SCRATCH  = 8;
    localparam int          REG_MODE_SEL = 9;
    localparam int          REG_FSEL     = 10;
    localparam int          REG_ENH_FUNC = 11;
    localparam int          REG_XON1  = 12;
    localparam int          REG_XON2  = 13;
    localparam int          REG_XOFF1 = 14;
    localparam int          REG_XOFF2 = 15;
    localparam int          NUM_REGS  = 16;

    // One host access as seen in a single clock cycle
    typedef struct packed {
        logic               cs;
        logic               rd;
        logic               wr;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
    } host_req_t;

    // Status bytes supplied by the rest of the UART
    typedef struct packed {
        logic [DATA_W-1:0]  rx_data;
        logic [DATA_W-1:0]  int_status;
        logic [DATA_W-1:0]  line_state;
        logic [DATA_W-1:0]  modem_state;
        logic [DATA_W-1:0]  fifo_level;
    } uart_status_t;

    // Stored configuration handed to the rest of the UART
    typedef struct packed {
        logic [DATA_W-1:0]  divisor_low;
        logic [DATA_W-1:0]  divisor_high;
        logic [DATA_W-1:0]  divisor_fraction;
        logic [DATA_W-1:0]  interrupt_enables;
        logic [DATA_W-1:0]  fifo_setup;
        logic [DATA_W-1:0]  line_setup;
        logic [DATA_W-1:0]  modem_outputs;
        logic [DATA_W-1:0]  modem_side_control;
        logic [DATA_W-1:0]  scratch_byte;
        logic [DATA_W-1:0]  enhanced_mode_select;
        logic [DATA_W-1:0]  feature_select;
        logic [DATA_W-1:0]  enhanced_function;
        logic [DATA_W-1:0]  flow_resume_char_1;
        logic [DATA_W-1:0]  flow_resume_char_2;
        logic [DATA_W-1:0]  flow_stop_char_1;
        logic [DATA_W-1:0]  flow_stop_char_2;
    } uart_config_t;

endpackage

// file: verification/host_bus_model.sv
// Host processor model that makes one register access at a time
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import uart_regs_pkg::*;
(
    input  wire logic      clk_sys_i,
    output var  host_req_t host_o
);
    initial host_o = '0;
    // Released lines are inverted so a stale address or byte is never taken for live
    task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        host_o <= '{cs: 1'b1, rd: rd, wr: ~rd, addr: a, wdata: d};
        @(posedge clk_sys_i);
        host_o <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask
    task automatic bank(input logic [7:0] v);
        access(1'b0, 3'h3, v);
    endtask
endmodule // host_bus_model
`default_nettype wire

// file: verification/uart_register_address_decode_tb_top.sv
// Self-checking testbench of the banked register decoder
`timescale 1ns/1ns
`default_nettype none
module uart_register_address_decode_tb_top;
    import uart_regs_pkg::*;
    logic         clk_sys_i, rst_i, rx_pop_o, tx_load_o, rx_fifo_reset_o, tx_fifo_reset_o;
    logic         int_status_read_o, line_state_read_o, modem_state_read_o;
    logic [7:0]   rdata_o, tx_data_o, int_enables_eff_o;
    host_req_t    host_i;
    uart_status_t status_i;
    uart_config_t config_o;
    int           n_errors = 0;
    int           total_checks = 0;
    uart_register_address_decode u_uart_register_address_decode (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .host_i(host_i), .status_i(status_i), .rdata_o(rdata_o),
        .rx_pop_o(rx_pop_o), .tx_load_o(tx_load_o), .tx_data_o(tx_data_o),
        .rx_fifo_reset_o(rx_fifo_reset_o), .tx_fifo_reset_o(tx_fifo_reset_o),
        .int_status_read_o(int_status_read_o), .line_state_read_o(line_state_read_o),
        .modem_state_read_o(modem_state_read_o), .int_enables_eff_o(int_enables_eff_o),
        .config_o(config_o));
    host_bus_model u_host_bus_model (.clk_sys_i(clk_sys_i), .host_o(host_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host_bus_model.access(1'b0, a, d);
    endtask
    // Read data lands on the taking edge, so it is compared just after it
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        u_host_bus_model.access(1'b1, a, 8'h00);
        chk(rdata_o, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_divisor();
        u_host_bus_model.bank(8'h80);
        rd(3'h0, 8'h5a);
        rd(3'h1, 8'ha5);
        wr(3'h0, 8'h12);
        chk(config_o.divisor_low, 8'h12);
        rd(3'h1, 8'h00);
        wr(3'h1, 8'h34);
        rd(3'h1, 8'h34);
        rd(3'h0, 8'h12);
        rd(3'h2, 8'h0c);
        $display("test divisor done");
    endtask
    task automatic t_normal();
        logic [127:0] snap;
        u_host_bus_model.bank(8'h00);
        rd(3'h0, 8'h11);
        chk(rx_pop_o, 1'b1);
        wr(3'h0, 8'h55);
        chk({tx_load_o, tx_data_o}, 9'h155);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'h0f);
        chk(int_enables_eff_o, 8'h0f);
        wr(3'h2, 8'h07);
        chk({rx_fifo_reset_o, tx_fifo_reset_o, config_o.fifo_setup}, 10'h301);
        wr(3'h2, 8'h04);
        chk({rx_fifo_reset_o, tx_fifo_reset_o, config_o.fifo_setup}, 10'h100);
        wr(3'h2, 8'hc8);
        chk(config_o.fifo_setup, 8'hc8);
        rd(3'h2, 8'h0c);
        chk(int_status_read_o, 1'b1);
        rd(3'h5, 8'h61);
        chk(line_state_read_o, 1'b1);
        snap = config_o;
        wr(3'h5, 8'hee);
        wr(3'h6, 8'hee);
        chk(config_o, snap);
        rd(3'h6, 8'hb2);
        chk(modem_state_read_o, 1'b1);
        wr(3'h4, 8'h0b);
        rd(3'h4, 8'h0b);
        wr(3'h7, 8'h99);
        rd(3'h7, 8'h99);
        rd(3'h3, 8'h00);
        $display("test normal bank done");
    endtask
    task automatic t_enhanced();
        logic [127:0] snap;
        u_host_bus_model.bank(8'hbf);
        wr(3'h2, 8'h10);
        rd(3'h2, 8'h10);
        wr(3'h1, 8'h40);
        rd(3'h1, 8'h40);
        for (int a = 4; a < 8; a++) wr(a[2:0], 8'hc0 + a[7:0]);
        for (int a = 4; a < 8; a++) rd(a[2:0], 8'hc0 + a[7:0]);
        rd(3'h0, 8'h07);
        rd(3'h3, 8'hbf);
        snap = config_o;
        wr(3'h0, 8'h77);
        chk(config_o, snap);
        $display("test enhanced bank done");
    endtask
    task automatic t_enh_on();
        u_host_bus_model.bank(8'h00);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'hff);
        chk(int_enables_eff_o, 8'hff);
        rd(3'h2, 8'h3c);
        chk(int_status_read_o, 1'b1);
        wr(3'h6, 8'h80);
        chk(config_o.modem_side_control, 8'h80);
        wr(3'h7, 8'h3c);
        chk(config_o.enhanced_mode_select, 8'h3c);
        chk(config_o.scratch_byte, 8'h99);
        rd(3'h7, 8'h07);
        u_host_bus_model.bank(8'h80);
        wr(3'h2, 8'h5d);
        rd(3'h2, 8'h5d);
        $display("test enhanced features done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_i = 1'b1;
        status_i = '{8'h11, 8'h3c, 8'h61, 8'hb2, 8'h07};
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        chk(config_o, '0);
        t_divisor();
        t_normal();
        t_enhanced();
        t_enh_on();
        give_verdict();
    end
    // A hung run counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_errors++;
        give_verdict();
    end
endmodule // uart_register_address_decode_tb_top
`default_nettype wire

// file: verilog/reg_byte.sv
// One host-writable storage register with load enable
`timescale 1ns/1ns
`default_nettype none

module reg_byte
    import uart_regs_pkg::*;
#(
    parameter int               WIDTH     = DATA_W,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("reg_byte: WIDTH must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= RST_VALUE;
        end else if (load_i) begin
            q_o <= d_i;
        end
    end

endmodule // reg_byte

`default_nettype wire

// file: verilog/uart_register_address_decode.sv
// Banked register decoder and register bank of an enhanced UART
`timescale 1ns/1ns
`default_nettype none

module uart_register_address_decode
    import uart_regs_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5a,  // Arbitrary value
    parameter logic [7:0] IDENT_CODE    = 8'ha5   // Arbitrary value
) (
    input  wire logic          clk_sys_i,
    input  wire logic          rst_i,
    input  wire host_req_t     host_i,
    input  wire uart_status_t  status_i,
    output var  logic [7:0]    rdata_o,
    output var  logic          rx_pop_o,
    output var  logic          tx_load_o,
    output var  logic [7:0]    tx_data_o,
    output var  logic          rx_fifo_reset_o,
    output var  logic          tx_fifo_reset_o,
    output var  logic          int_status_read_o,
    output var  logic          line_state_read_o,
    output var  logic          modem_state_read_o,
    output var  logic [7:0]    int_enables_eff_o,
    output var  uart_config_t  config_o
);

    // The decode below serves a byte bus with eight locations and nothing wider
    generate
        if (DATA_W != 8 || ADDR_W != 3) begin : g_bad_bus
            $error("uart_register_address_decode: byte bus with 3-bit address only");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bank selection

    logic [7:0] bank_q [NUM_REGS];
    logic [7:0] bank_d [NUM_REGS];
    logic       bank_we [NUM_REGS];

    wire logic       wr_hit   = host_i.cs & host_i.wr;
    wire logic       rd_hit   = host_i.cs & host_i.rd;
    wire logic [7:0] wd       = host_i.wdata;
    wire logic [7:0] line_cur = bank_q[REG_LINE];
    wire logic       key_bank = (line_cur == ENH_BANK_KEY);
    wire logic       div_on   = line_cur[LS_DIV_BIT];
    wire logic       enh_on   = bank_q[REG_ENH_FUNC][EF_ENH_BIT];
    wire logic       fsel_on  = bank_q[REG_FSEL][FS_SEL_BIT];
    wire logic       div_zero = (bank_q[REG_DIV_LOW] == DIVISOR_ZERO)
                              & (bank_q[REG_DIV_HIGH] == DIVISOR_ZERO);

    wire logic at0 = (host_i.addr == ADDR_0);
    wire logic at1 = (host_i.addr == ADDR_1);
    wire logic at2 = (host_i.addr == ADDR_2);
    wire logic at3 = (host_i.addr == ADDR_3);
    wire logic at4 = (host_i.addr == ADDR_4);
    wire logic at5 = (host_i.addr == ADDR_5);
    wire logic at6 = (host_i.addr == ADDR_6);
    wire logic at7 = (host_i.addr == ADDR_7);

    // The key value has bit 7 set, so a clear divisor bit already excludes it
    wire logic sel_div_low  = at0 & div_on & ~key_bank;
    wire logic sel_div_high = at1 & div_on & ~key_bank;
    wire logic sel_div_frac = at2 & div_on & ~key_bank & enh_on;
    wire logic sel_rx_tx    = at0 & ~div_on;
    wire logic sel_int_en   = at1 & ~div_on;
    wire logic sel_int_st   = at2 & ~key_bank & ~(div_on & enh_on);
    wire logic sel_line     = at3;
    wire logic sel_modem    = at4 & ~key_bank;
    wire logic sel_line_st  = at5 & ~key_bank;
    wire logic sel_modem_st = at6 & ~key_bank;
    wire logic sel_msw      = at6 & ~key_bank & enh_on;
    wire logic sel_scratch  = at7 & ~key_bank & ~fsel_on;
    wire logic sel_mode_sel = at7 & ~key_bank & fsel_on;
    wire logic sel_level0   = at0 & key_bank;
    wire logic sel_fsel     = at1 & key_bank;
    wire logic sel_enh_func = at2 & key_bank;
    wire logic sel_xon1     = at4 & key_bank;
    wire logic sel_xon2     = at5 & key_bank;
    wire logic sel_xoff1    = at6 & key_bank;
    wire logic sel_xoff2    = at7 & key_bank;

    ////////////////////////////////////////////////////////////////////////////
    // Write path

    // Only stored bytes get a load; read-only selections have none at all
    assign bank_we[REG_DIV_LOW]  = wr_hit & sel_div_low;
    assign bank_we[REG_DIV_HIGH] = wr_hit & sel_div_high;
    assign bank_we[REG_DIV_FRAC] = wr_hit & sel_div_frac;
    assign bank_we[REG_INT_EN]   = wr_hit & sel_int_en;
    assign bank_we[REG_FIFO]     = wr_hit & sel_int_st;
    assign bank_we[REG_LINE]     = wr_hit & sel_line;
    assign bank_we[REG_MODEM]    = wr_hit & sel_modem;
    assign bank_we[REG_MSW]      = wr_hit & sel_msw;
    assign bank_we[REG_SCRATCH]  = wr_hit & sel_scratch;
    assign bank_we[REG_MODE_SEL] = wr_hit & sel_mode_sel;
    assign bank_we[REG_FSEL]     = wr_hit & sel_fsel;
    assign bank_we[REG_ENH_FUNC] = wr_hit & sel_enh_func;
    assign bank_we[REG_XON1]  = wr_hit & sel_xon1;
    assign bank_we[REG_XON2]  = wr_hit & sel_xon2;
    assign bank_we[REG_XOFF1] = wr_hit & sel_xoff1;
    assign bank_we[REG_XOFF2] = wr_hit & sel_xoff2;

    // Enhanced enables keep their old value unless enhanced mode is on
    wire logic [7:0] nxt_int_en = enh_on ? wd
        : ((bank_q[REG_INT_EN] & INT_EN_ENH_MASK) | (wd & ~INT_EN_ENH_MASK));
    // FIFO reset bits act as pulses and are never stored
    wire logic [7:0] nxt_fifo = wd & FIFO_KEEP_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_bank
            assign bank_d[gi] = (gi == REG_INT_EN) ? nxt_int_en
                              : (gi == REG_FIFO) ? nxt_fifo
                              : wd;
            reg_byte #(
                .WIDTH     (DATA_W),
                .RST_VALUE (RST_REG_VALUE)
            ) u_reg (
                .clk_sys_i (clk_sys_i),
                .rst_i     (rst_i),
                .load_i    (bank_we[gi]),
                .d_i       (bank_d[gi]),
                .q_o       (bank_q[gi])
            );
        end
    endgenerate

    assign config_o.divisor_low          = bank_q[REG_DIV_LOW];
    assign config_o.divisor_high         = bank_q[REG_DIV_HIGH];
    assign config_o.divisor_fraction     = bank_q[REG_DIV_FRAC];
    assign config_o.interrupt_enables    = bank_q[REG_INT_EN];
    assign config_o.fifo_setup           = bank_q[REG_FIFO];
    assign config_o.line_setup           = bank_q[REG_LINE];
    assign config_o.modem_outputs        = bank_q[REG_MODEM];
    assign config_o.modem_side_control   = bank_q[REG_MSW];
    assign config_o.scratch_byte         = bank_q[REG_SCRATCH];
    assign config_o.enhanced_mode_select = bank_q[REG_MODE_SEL];
    assign config_o.feature_select       = bank_q[REG_FSEL];
    assign config_o.enhanced_function    = bank_q[REG_ENH_FUNC];
    assign config_o.flow_resume_char_1   = bank_q[REG_XON1];
    assign config_o.flow_resume_char_2   = bank_q[REG_XON2];
    assign config_o.flow_stop_char_1     = bank_q[REG_XOFF1];
    assign config_o.flow_stop_char_2     = bank_q[REG_XOFF2];

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    wire logic [7:0] enh_int_en_mask = enh_on ? 8'hff : ~INT_EN_ENH_MASK;
    wire logic [7:0] enh_int_st_mask = enh_on ? 8'hff : ~INT_ST_ENH_MASK;

    wire logic [7:0] rd_div_low  = div_zero ? REVISION_CODE : bank_q[REG_DIV_LOW];
    wire logic [7:0] rd_div_high = div_zero ? IDENT_CODE : bank_q[REG_DIV_HIGH];

    wire logic [7:0] rd_mux =
          sel_div_low  ? rd_div_low
        : sel_div_high ? rd_div_high
        : sel_div_frac ? bank_q[REG_DIV_FRAC]
        : sel_rx_tx    ? status_i.rx_data
        : sel_int_en   ? (bank_q[REG_INT_EN] & enh_int_en_mask)
        : sel_int_st   ? (status_i.int_status & enh_int_st_mask)
        : sel_line     ? bank_q[REG_LINE]
        : sel_modem    ? bank_q[REG_MODEM]
        : sel_line_st  ? status_i.line_state
        : sel_modem_st ? status_i.modem_state
        : sel_scratch  ? bank_q[REG_SCRATCH]
        : sel_mode_sel ? status_i.fifo_level
        : sel_level0   ? status_i.fifo_level
        : sel_fsel     ? bank_q[REG_FSEL]
        : sel_enh_func ? bank_q[REG_ENH_FUNC]
        : sel_xon1     ? bank_q[REG_XON1]
        : sel_xon2     ? bank_q[REG_XON2]
        : sel_xoff1    ? bank_q[REG_XOFF1]
        : sel_xoff2    ? bank_q[REG_XOFF2]
        : BYTE_ZERO;

    // Side effects of reads are strobes only; no stored byte changes on a read
    wire logic nxt_rx_pop        = rd_hit & sel_rx_tx;
    wire logic nxt_int_st_read   = rd_hit & sel_int_st;
    wire logic nxt_line_st_read  = rd_hit & sel_line_st;
    wire logic nxt_modem_st_read = rd_hit & sel_modem_st;
    wire logic nxt_tx_load       = wr_hit & sel_rx_tx;
    wire logic nxt_rx_rst        = wr_hit & sel_int_st & wd[FIFO_RXRST_BIT];
    wire logic nxt_tx_rst        = wr_hit & sel_int_st & wd[FIFO_TXRST_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Output flip-flops

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= BYTE_ZERO;
        end else if (rd_hit) begin
            rdata_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_data_o <= BYTE_ZERO;
        end else if (nxt_tx_load) begin
            tx_data_o <= wd;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_pop_o        <= 1'b0;
            tx_load_o       <= 1'b0;
            rx_fifo_reset_o <= 1'b0;
            tx_fifo_reset_o <= 1'b0;
            int_status_read_o  <= 1'b0;
            line_state_read_o  <= 1'b0;
            modem_state_read_o <= 1'b0;
        end else begin
            rx_pop_o           <= nxt_rx_pop;
            tx_load_o          <= nxt_tx_load;
            rx_fifo_reset_o    <= nxt_rx_rst;
            tx_fifo_reset_o    <= nxt_tx_rst;
            int_status_read_o  <= nxt_int_st_read;
            line_state_read_o  <= nxt_line_st_read;
            modem_state_read_o <= nxt_modem_st_read;
        end
    end

    // Enables as the interrupt logic must see them
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            int_enables_eff_o <= RST_REG_VALUE;
        end else begin
            int_enables_eff_o <= bank_q[REG_INT_EN] & enh_int_en_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb_sys @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    wire logic [NUM_REGS*8-1:0] bank_flat;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_flat
            assign bank_flat[gi*8 +: 8] = bank_q[gi];
        end
    endgenerate

    sequence s_fifo_reset_write;
        wr_hit && at2 && !key_bank && !(div_on && enh_on) && wd[FIFO_RXRST_BIT];
    endsequence

    sequence s_reset_pulse_once;
        rx_fifo_reset_o ##1 !rx_fifo_reset_o;
    endsequence

    // Back-to-back reset writes legally stretch the pulse, so they are left out
    sequence s_no_reset_follows;
        !nxt_rx_rst;
    endsequence

    a_line_setup_write: assert property (
        wr_hit && at3 |=> config_o.line_setup == $past(wd))
        else $error("line setup did not take the written byte");

    a_div_low_gate: assert property (
        wr_hit && at0 && !div_on |=> $stable(config_o.divisor_low) && tx_load_o)
        else $error("divisor low byte written outside divisor access");

    a_rev_ident_read: assert property (
        rd_hit && at0 && div_on && !key_bank && div_zero |=> rdata_o == REVISION_CODE)
        else $error("revision code not returned for zero divisor");

    a_ident_read: assert property (
        rd_hit && at1 && div_on && !key_bank && div_zero |=> rdata_o == IDENT_CODE)
        else $error("identification code not returned for zero divisor");

    a_rx_read_pop: assert property (
        rd_hit && at0 && !div_on |=> rx_pop_o && rdata_o == $past(status_i.rx_data))
        else $error("receive byte read did not pop or return data");

    a_int_en_zero: assert property (
        rd_hit && at1 && !div_on && !enh_on |=> (rdata_o & INT_EN_ENH_MASK) == BYTE_ZERO)
        else $error("enhanced enable bits visible with enhanced mode off");

    a_int_st_zero: assert property (
        rd_hit && at2 && !key_bank && !div_on && !enh_on
        |=> (rdata_o & INT_ST_ENH_MASK) == BYTE_ZERO)
        else $error("enhanced status bits visible with enhanced mode off");

    a_fifo_reset_pulse: assert property (
        s_fifo_reset_write ##1 s_no_reset_follows |-> s_reset_pulse_once)
        else $error("receive FIFO reset is not a single pulse");

    a_tx_reset_pulse: assert property (
        wr_hit && at2 && !key_bank && !div_on && wd[FIFO_TXRST_BIT]
        |=> tx_fifo_reset_o && !config_o.fifo_setup[FIFO_TXRST_BIT])
        else $error("transmit FIFO reset did not pulse or was stored");

    a_ro_write_drop: assert property (
        wr_hit && (at5 || at0) && !key_bank && !div_on && !at0
        |=> bank_flat == $past(bank_flat))
        else $error("write to line state changed a stored byte");

    a_read_no_change: assert property (
        rd_hit && !wr_hit |=> bank_flat == $past(bank_flat))
        else $error("a read changed a stored byte");

    a_mode_sel_write: assert property (
        wr_hit && at7 && !key_bank && fsel_on
        |=> config_o.enhanced_mode_select == $past(wd) && $stable(config_o.scratch_byte))
        else $error("mode select write misrouted");

    a_key_bank_level: assert property (
        rd_hit && at0 && key_bank |=> rdata_o == $past(status_i.fifo_level) && !rx_pop_o)
        else $error("enhanced bank address 0 did not return FIFO level");

    a_msw_gate: assert property (
        wr_hit && at6 && !key_bank && !enh_on |=> $stable(config_o.modem_side_control))
        else $error("modem-side control written with enhanced mode off");

endmodule // uart_register_address_decode

`default_nettype wire
